/* File: rtl/clc_edge_cond.sv */
// Purpose: Deglitch filter or edge detector with selectable edge mode and width.
// Assumes: Input is synchronous to clk.
// Notes: Filter passes a level only after it holds for the chosen width.
`timescale 1ns/1ps
module clc_edge_cond
    import clc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic edge_mode,
    input wire logic invert,
    input wire logic [1:0] edge_sel,
    input wire logic [CNT_W-1:0] width_cyc,
    input wire logic sig_in,
    output logic sig_out
);
    logic prev_r;
    logic prev_nxt;
    logic out_r;
    logic out_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic rise;
    logic fall;

    always_comb begin
        rise = sig_in && !prev_r;
        fall = !sig_in && prev_r;
        prev_nxt = sig_in;
        out_nxt = out_r;
        cnt_nxt = cnt_r;
        if (!edge_mode || edge_sel == EDGE_DELAY) begin
            // Filter and delay both pass the input level after it is stable for the width.
            if (rise || fall) begin
                cnt_nxt = width_cyc;
            end else if (cnt_r != '0) begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == CNT_W'(1)) begin
                    out_nxt = sig_in;
                end
            end else begin
                out_nxt = sig_in;
            end
        end else begin
            if ((edge_sel == EDGE_RISE && rise) || (edge_sel == EDGE_FALL && fall)
                    || (edge_sel == EDGE_BOTH && (rise || fall))) begin
                cnt_nxt = width_cyc;
                out_nxt = 1'b1;
            end else if (cnt_r > CNT_W'(1)) begin
                cnt_nxt = cnt_r - 1'b1;
            end else begin
                cnt_nxt = '0;
                out_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev_r <= 1'b0;
            out_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            prev_r <= prev_nxt;
            out_r <= out_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign sig_out = out_r ^ invert;

    chk_polarity_apply: assert property (@(posedge clk) disable iff (!rst_b)
        (edge_mode && edge_sel == EDGE_RISE && sig_in && !prev_r) ##1 $stable(invert)
        |-> (sig_out == !invert))
        else $error("Polarity select not applied.");
    chk_rise_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        (edge_mode && edge_sel == EDGE_RISE && sig_in && !prev_r) |=> out_r)
        else $error("Rising edge gave no pulse.");
endmodule

/* File: rtl/clc_pkg.sv */
// Purpose: Shared constants for the configurable logic cells block.
// Assumes: Configuration bytes are addressed by byte offset in the configuration space.
// Notes: Timing counts are derived from a 40 MHz clock.
package clc_pkg;
    localparam int unsigned CLK_PERIOD_PS = 25000;
    localparam logic [7:0] OFS_EDGE_FILTER = 8'hb5;
    localparam logic [7:0] OFS_TWO_ZERO_ONE = 8'hbb;
    localparam logic [7:0] OFS_THREE_FIVE = 8'hb6;
    localparam logic [7:0] OFS_THREE_SIX = 8'hb7;
    localparam logic [7:0] OFS_THREE_SEVEN = 8'hb8;
    localparam logic [7:0] OFS_THREE_EIGHT = 8'hb9;
    localparam logic [7:0] OFS_FUNC_SEL = 8'hba;
    localparam logic [7:0] OFS_TWO_TWO = 8'hbc;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] FUNC_SEL_WMASK = 8'hf7;
    localparam logic [7:0] TWO_TWO_WMASK = 8'h0f;
    // Edge filter byte fields.
    localparam int EF_MODE_BIT = 0;
    localparam int EF_POL_BIT = 1;
    localparam int EF_EDGE_LSB = 2;
    localparam int EF_TIME_LSB = 4;
    localparam int EF_DLY_LSB = 6;
    // Storage field positions for three-input and two-input cells.
    localparam int T3_LATCH_BIT = 7;
    localparam int T3_PHASE_BIT = 6;
    localparam int T3_INIT_BIT = 5;
    localparam int T3_SET_BIT = 4;
    localparam int T3_LVL_BIT = 3;
    localparam int T2_LATCH_BIT = 3;
    localparam int T2_PHASE_BIT = 2;
    localparam int T2_INIT_BIT = 1;
    localparam int T3_FSEL_LSB = 4;
    localparam int T2_ONE_LSB = 4;
    // Edge mode codes.
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_DELAY = 2'h3;
    // Pulse widths in nanoseconds; code 01 is taken as 250 ns.
    localparam int unsigned T_125_NS = 125;
    localparam int unsigned T_250_NS = 250;
    localparam int unsigned T_375_NS = 375;
    localparam int unsigned T_500_NS = 500;
    localparam int unsigned CYC_125 = (T_125_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CYC_250 = (T_250_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CYC_375 = (T_375_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CYC_500 = (T_500_NS * 1000) / CLK_PERIOD_PS;
    localparam int CNT_W = 5;
    typedef enum logic [2:0] {
        EF_IDLE = 3'b001,
        EF_PULSE = 3'b010,
        EF_WAIT = 3'b100
    } clc_ef_state_t;
endpackage

/* File: rtl/clc_storage.sv */
// Purpose: Storage element of one combined cell: flip-flop or latch with reset or set.
// Assumes: Data, clock and control come from the routing matrix, synchronous to clk.
// Notes: The matrix clock is sampled; a flip-flop loads on its sampled rising edge.
`timescale 1ns/1ps
module clc_storage
    import clc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cfg_load,
    input wire logic latch_mode,
    input wire logic out_phase,
    input wire logic init_high,
    input wire logic ctl_is_set,
    input wire logic ctl_act_high,
    input wire logic d_in,
    input wire logic mclk,
    input wire logic ctl_in,
    output logic q_out
);
    logic q_r;
    logic q_nxt;
    logic mclk_r;
    logic mclk_nxt;
    logic ctl_act;

    always_comb begin
        ctl_act = (ctl_in == ctl_act_high);
        mclk_nxt = mclk;
        q_nxt = q_r;
        if (cfg_load) begin
            q_nxt = init_high;
        end else if (ctl_act) begin
            q_nxt = ctl_is_set;
        end else if (latch_mode) begin
            if (mclk) begin
                q_nxt = d_in;
            end
        end else if (mclk && !mclk_r) begin
            q_nxt = d_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q_r <= 1'b0;
            mclk_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
            mclk_r <= mclk_nxt;
        end
    end

    assign q_out = q_r ^ out_phase;

    chk_control_forces: assert property (@(posedge clk) disable iff (!rst_b)
        (!cfg_load && ctl_in == ctl_act_high) |=> (q_r == $past(ctl_is_set)))
        else $error("Control input did not force the storage level.");
    chk_phase_select: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_load ##1 $stable(out_phase) |-> (q_out == ($past(init_high) != out_phase)))
        else $error("Output phase does not follow select.");
    chk_init_level: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_load |=> (q_r == $past(init_high)))
        else $error("Initial level not applied on load.");
    chk_ff_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (!cfg_load && ctl_in != ctl_act_high && !latch_mode && !(mclk && !mclk_r))
        |=> $stable(q_r))
        else $error("Flip-flop changed without a clock edge.");
endmodule

/* File: rtl/clc_top.sv */
// Purpose: Configurable logic cells: edge conditioner plus three two-input and four
//   three-input combined cells, each a table or a storage element.
// Assumes: Configuration bytes are written through a byte port at documented offsets;
//   matrix signals are synchronous to clk.
// Notes: cfg_load marks the end of configuration loading and applies initial levels.
`timescale 1ns/1ps
module clc_top
    import clc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic cfg_load,
    input wire logic cond_in,
    output logic cond_out,
    input wire logic dly_in,
    output logic dly_out,
    input wire logic [1:0] two_in_a,
    input wire logic [1:0] two_in_b,
    input wire logic [1:0] two_in_c,
    output logic [2:0] two_out,
    input wire logic [2:0] three_in_five,
    input wire logic [2:0] three_in_six,
    input wire logic [2:0] three_in_seven,
    input wire logic [2:0] three_in_eight,
    output logic [3:0] three_out
);
    import clc_pkg::*;

    logic [7:0] edge_cfg_r;
    logic [7:0] edge_cfg_nxt;
    logic [7:0] two01_cfg_r;
    logic [7:0] two01_cfg_nxt;
    logic [7:0] two2_cfg_r;
    logic [7:0] two2_cfg_nxt;
    logic [7:0] fsel_r;
    logic [7:0] fsel_nxt;
    logic [7:0] three_cfg_r [4];
    logic [7:0] three_cfg_nxt [4];
    logic [7:0] rdata_nxt;
    logic [3:0] two_nib [3];
    logic [1:0] two_ins [3];
    logic [2:0] three_ins [4];
    logic [2:0] two_q;
    logic [3:0] three_q;

    function automatic logic [CNT_W-1:0] width_of(input logic [1:0] code);
        logic [CNT_W-1:0] w;
        case (code)
            2'h0: w = CNT_W'(CYC_125);
            2'h1: w = CNT_W'(CYC_250);
            2'h2: w = CNT_W'(CYC_375);
            default: w = CNT_W'(CYC_500);
        endcase
        return w;
    endfunction

    always_comb begin
        edge_cfg_nxt = edge_cfg_r;
        two01_cfg_nxt = two01_cfg_r;
        two2_cfg_nxt = two2_cfg_r;
        fsel_nxt = fsel_r;
        for (int i = 0; i < 4; i++) begin
            three_cfg_nxt[i] = three_cfg_r[i];
        end
        if (cfg_we) begin
            case (cfg_addr)
                OFS_EDGE_FILTER: edge_cfg_nxt = cfg_wdata;
                OFS_TWO_ZERO_ONE: two01_cfg_nxt = cfg_wdata;
                OFS_TWO_TWO: two2_cfg_nxt = cfg_wdata & TWO_TWO_WMASK;
                OFS_FUNC_SEL: fsel_nxt = cfg_wdata & FUNC_SEL_WMASK;
                OFS_THREE_FIVE: three_cfg_nxt[0] = cfg_wdata;
                OFS_THREE_SIX: three_cfg_nxt[1] = cfg_wdata;
                OFS_THREE_SEVEN: three_cfg_nxt[2] = cfg_wdata;
                OFS_THREE_EIGHT: three_cfg_nxt[3] = cfg_wdata;
                default: ;
            endcase
        end
        case (cfg_addr)
            OFS_EDGE_FILTER: rdata_nxt = edge_cfg_r;
            OFS_TWO_ZERO_ONE: rdata_nxt = two01_cfg_r;
            OFS_TWO_TWO: rdata_nxt = two2_cfg_r;
            OFS_FUNC_SEL: rdata_nxt = fsel_r;
            OFS_THREE_FIVE: rdata_nxt = three_cfg_r[0];
            OFS_THREE_SIX: rdata_nxt = three_cfg_r[1];
            OFS_THREE_SEVEN: rdata_nxt = three_cfg_r[2];
            OFS_THREE_EIGHT: rdata_nxt = three_cfg_r[3];
            default: rdata_nxt = CFG_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            edge_cfg_r <= CFG_RESET;
            two01_cfg_r <= CFG_RESET;
            two2_cfg_r <= CFG_RESET;
            fsel_r <= CFG_RESET;
            cfg_rdata <= CFG_RESET;
            for (int i = 0; i < 4; i++) begin
                three_cfg_r[i] <= CFG_RESET;
            end
        end else begin
            edge_cfg_r <= edge_cfg_nxt;
            two01_cfg_r <= two01_cfg_nxt;
            two2_cfg_r <= two2_cfg_nxt;
            fsel_r <= fsel_nxt;
            cfg_rdata <= rdata_nxt;
            for (int i = 0; i < 4; i++) begin
                three_cfg_r[i] <= three_cfg_nxt[i];
            end
        end
    end

    // Deglitch filter or edge detector.
    clc_edge_cond u_cond (
        .clk(clk),
        .rst_b(rst_b),
        .edge_mode(edge_cfg_r[EF_MODE_BIT]),
        .invert(edge_cfg_r[EF_POL_BIT]),
        .edge_sel(edge_cfg_r[EF_EDGE_LSB +: 2]),
        .width_cyc(width_of(edge_cfg_r[EF_TIME_LSB +: 2])),
        .sig_in(cond_in),
        .sig_out(cond_out)
    );

    // Programmable delay with edge detector: edge mode tied on, no inversion; code 3 selects the delay path.
    clc_edge_cond u_dly (
        .clk(clk),
        .rst_b(rst_b),
        .edge_mode(1'b1),
        .invert(1'b0),
        .edge_sel(edge_cfg_r[EF_DLY_LSB +: 2]),
        .width_cyc(width_of(edge_cfg_r[EF_TIME_LSB +: 2])),
        .sig_in(dly_in),
        .sig_out(dly_out)
    );

    assign two_nib[0] = two01_cfg_r[3:0];
    assign two_nib[1] = two01_cfg_r[T2_ONE_LSB +: 4];
    assign two_nib[2] = two2_cfg_r[3:0];
    assign two_ins[0] = two_in_a;
    assign two_ins[1] = two_in_b;
    assign two_ins[2] = two_in_c;
    assign three_ins[0] = three_in_five;
    assign three_ins[1] = three_in_six;
    assign three_ins[2] = three_in_seven;
    assign three_ins[3] = three_in_eight;

    // Two-input cells: input 0 is data, input 1 the matrix clock in storage mode.
    for (genvar g = 0; g < 3; g++) begin : g_two
        clc_storage u_st (
            .clk(clk),
            .rst_b(rst_b),
            .cfg_load(cfg_load),
            .latch_mode(two_nib[g][T2_LATCH_BIT]),
            .out_phase(two_nib[g][T2_PHASE_BIT]),
            .init_high(two_nib[g][T2_INIT_BIT]),
            .ctl_is_set(1'b0),
            .ctl_act_high(1'b1),
            .d_in(two_ins[g][0]),
            .mclk(two_ins[g][1]),
            .ctl_in(1'b0),
            .q_out(two_q[g])
        );
        assign two_out[g] = fsel_r[g] ? two_q[g] : two_nib[g][two_ins[g]];
    end

    // Three-input cells: inputs are data, matrix clock and reset or set in storage mode.
    for (genvar g = 0; g < 4; g++) begin : g_three
        logic [7:0] tbl;
        clc_storage u_st (
            .clk(clk),
            .rst_b(rst_b),
            .cfg_load(cfg_load),
            .latch_mode(three_cfg_r[g][T3_LATCH_BIT]),
            .out_phase(three_cfg_r[g][T3_PHASE_BIT]),
            .init_high(three_cfg_r[g][T3_INIT_BIT]),
            .ctl_is_set(three_cfg_r[g][T3_SET_BIT]),
            .ctl_act_high(three_cfg_r[g][T3_LVL_BIT]),
            .d_in(three_ins[g][0]),
            .mclk(three_ins[g][1]),
            .ctl_in(three_ins[g][2]),
            .q_out(three_q[g])
        );
        assign tbl = three_cfg_r[g];
        assign three_out[g] = fsel_r[T3_FSEL_LSB + g] ? three_q[g]
                                                       : tbl[three_ins[g]];
    end

    chk_table_mode: assert property (@(posedge clk) disable iff (!rst_b)
        !fsel_r[T3_FSEL_LSB] |-> three_out[0] == three_cfg_r[0][three_in_five])
        else $error("Table output wrong for cell five.");
    chk_two_table: assert property (@(posedge clk) disable iff (!rst_b)
        !fsel_r[0] |-> two_out[0] == two01_cfg_r[two_in_a])
        else $error("Two-input table output wrong.");
    chk_fsel_write: assert property (@(posedge clk) disable iff (!rst_b)
        (cfg_we && cfg_addr == OFS_FUNC_SEL) |=> fsel_r[3] == 1'b0)
        else $error("Reserved function select bit stored.");
endmodule

/* File: verification/clc_matrix_model.sv */
// Purpose: Routing matrix model that feeds every combined cell of the block.
// Assumes: One 3-bit vector reaches all cells: bit0 data, bit1 clock, bit2 control.
// Notes: One register stage stands for the routing delay, so cell inputs move only on clk.
`timescale 1ns/1ps
module clc_matrix_model (
    input wire logic clk,
    input wire logic [2:0] vec,
    output logic [2:0] mvec_r
);
    always_ff @(posedge clk) begin
        mvec_r <= vec;
    end
endmodule

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the configurable logic cells.
// Assumes: Pulse widths follow the package cycle counts at 40 MHz.
// Notes: A monitor compares sampled outputs against a queue of expected values.
`timescale 1ns/1ps
module testbench;
    import clc_pkg::*;
    logic clk, rst_b, cfg_we, cfg_load, cond_in, cond_out, dly_in, dly_out;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, meas_r, obs, d, nib;
    logic [2:0] vec, mvec, two_out;
    logic [3:0] three_out, n2;
    logic ph, ini, sr, lv;
    logic [7:0] expq[$];
    logic [7:0] tbl [4];
    logic [7:0] wid [4] = '{8'(CYC_125), 8'(CYC_250), 8'(CYC_375), 8'(CYC_500)};
    logic [7:0] offs [9] = '{OFS_EDGE_FILTER, OFS_TWO_ZERO_ONE, OFS_THREE_FIVE, OFS_THREE_SIX,
        OFS_THREE_SEVEN, OFS_THREE_EIGHT, OFS_FUNC_SEL, OFS_TWO_TWO, 8'hBD};
    logic [7:0] masks [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, FUNC_SEL_WMASK,
        TWO_TWO_WMASK, 8'h00};
    int err_count = 0;
    int check_count = 0;
    int chk_id = 0;
    int seen = 0;
    int chk_sel = 0;
    int cyc = 0;

    clc_matrix_model mm (.clk(clk), .vec(vec), .mvec_r(mvec));
    clc_top dut (.clk(clk), .rst_b(rst_b), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_load(cfg_load),
        .cond_in(cond_in), .cond_out(cond_out), .dly_in(dly_in), .dly_out(dly_out),
        .two_in_a(mvec[1:0]), .two_in_b(mvec[1:0]), .two_in_c(mvec[1:0]),
        .two_out(two_out), .three_in_five(mvec), .three_in_six(mvec),
        .three_in_seven(mvec), .three_in_eight(mvec), .three_out(three_out));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Sampling on the falling edge keeps the compare clear of the design's updates.
    always @(negedge clk) begin
        if (chk_id != seen) begin
            seen = chk_id;
            case (chk_sel)
                0: obs = cfg_rdata;
                1: obs = {7'h00, cond_out};
                2: obs = {5'h00, two_out};
                3: obs = {4'h0, three_out};
                4: obs = {7'h00, three_out[0]};
                6: obs = {7'h00, dly_out};
                default: obs = meas_r;
            endcase
            check_count++;
            if (obs !== expq[0]) begin
                err_count++;
                $display("wrong value at %0t exp %h got %h", $time, expq[0], obs);
            end
            void'(expq.pop_front());
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
    endtask

    task automatic check(input int s, input logic [7:0] e);
        expq.push_back(e);
        chk_sel <= s;
        chk_id <= chk_id + 1;
        tick();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        cfg_we <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= v;
        tick();
        cfg_we <= 1'b0;
        tick();
    endtask

    task automatic load();
        cfg_load <= 1'b1;
        tick();
        cfg_load <= 1'b0;
        tick();
    endtask

    // The wait covers the matrix stage plus the sampling of the matrix clock.
    task automatic setv(input logic [2:0] v);
        vec <= v;
        tick(4);
    endtask

    task automatic meas(input int n, input logic idl, input logic w);
        meas_r = 8'h00;
        repeat (n) begin
            @(negedge clk);
            if ((w ? dly_out : cond_out) !== idl) meas_r++;
        end
        @(posedge clk);
    endtask

    initial begin
        rst_b = 1'b0;
        cfg_we = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        cfg_load = 1'b0;
        cond_in = 1'b0;
        dly_in = 1'b0;
        vec = 3'h0;
        void'($urandom(87));
        tick(4);
        rst_b <= 1'b1;
        tick();
        foreach (offs[i]) begin
            cfg_addr <= offs[i];
            tick();
            check(0, CFG_RESET);
            d = 8'($urandom);
            wr(offs[i], d);
            check(0, d & masks[i]);
            wr(offs[i], 8'h00);
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            tbl[i] = 8'($urandom);
            wr(OFS_THREE_FIVE + 8'(i), tbl[i]);
        end
        nib = 8'($urandom);
        n2 = 4'($urandom);
        wr(OFS_TWO_ZERO_ONE, nib);
        wr(OFS_TWO_TWO, {4'h0, n2});
        for (int v = 0; v < 8; v++) begin
            vec <= 3'(v);
            tick(2);
            check(3, {4'h0, tbl[3][v], tbl[2][v], tbl[1][v], tbl[0][v]});
            check(2, {5'h00, n2[v % 4], nib[4 + v % 4], nib[v % 4]});
        end
        $display("test tables done");
        wr(OFS_FUNC_SEL, 8'h10);
        for (int k = 0; k < 4; k++) begin
            ph = k[0];
            ini = k[1];
            wr(OFS_THREE_FIVE, {1'b0, ph, ini, 2'b01, 3'h0});
            setv(3'b000);
            load();
            check(4, {7'h00, ini ^ ph});
            setv({2'b00, ~ini});
            check(4, {7'h00, ini ^ ph});
            setv({2'b01, ~ini});
            check(4, {7'h00, ~ini ^ ph});
            setv({2'b01, ini});
            check(4, {7'h00, ~ini ^ ph});
        end
        wr(OFS_THREE_FIVE, 8'h88);
        setv(3'b010);
        setv(3'b011);
        check(4, 8'h01);
        setv(3'b001);
        setv(3'b000);
        check(4, 8'h01);
        for (int k = 0; k < 4; k++) begin
            sr = k[0];
            lv = k[1];
            wr(OFS_THREE_FIVE, {2'b00, ~sr, sr, lv, 3'h0});
            setv({~lv, 2'b00});
            load();
            check(4, {7'h00, ~sr});
            setv({lv, 2'b00});
            check(4, {7'h00, sr});
        end
        // Two-input cells in storage mode: cell zero and one flip-flops, cell two a latch.
        wr(OFS_TWO_ZERO_ONE, 8'h42);
        wr(OFS_TWO_TWO, 8'h08);
        wr(OFS_FUNC_SEL, 8'h07);
        setv(3'b000);
        load();
        check(2, 8'h03);
        setv(3'b011);
        check(2, 8'h05);
        setv(3'b000);
        check(2, 8'h05);
        $display("test storage done");
        for (int t = 0; t < 4; t++) begin
            wr(OFS_EDGE_FILTER, 8'(1 + (t << EF_TIME_LSB)));
            cond_in <= 1'b1;
            meas(30, 1'b0, 1'b0);
            check(5, wid[t]);
            cond_in <= 1'b0;
            meas(30, 1'b0, 1'b0);
            check(5, 8'h00);
        end
        wr(OFS_EDGE_FILTER, 8'(3 + (EDGE_BOTH << EF_EDGE_LSB)));
        for (int e = 0; e < 2; e++) begin
            cond_in <= ~cond_in;
            meas(30, 1'b1, 1'b0);
            check(5, wid[0]);
        end
        wr(OFS_EDGE_FILTER, 8'(1 + (EDGE_DELAY << EF_EDGE_LSB)));
        cond_in <= 1'b1;
        tick(2);
        check(1, 8'h00);
        tick(30);
        check(1, 8'h01);
        cond_in <= 1'b0;
        wr(OFS_EDGE_FILTER, 8'(3 << EF_TIME_LSB));
        tick(30);
        cond_in <= 1'b1;
        tick(2);
        cond_in <= 1'b0;
        meas(30, 1'b0, 1'b0);
        check(5, 8'h00);
        cond_in <= 1'b1;
        tick(30);
        check(1, 8'h01);
        $display("test conditioner done");
        for (int m = 0; m < 3; m++) begin
            wr(OFS_EDGE_FILTER, 8'(m << EF_DLY_LSB));
            dly_in <= 1'b1;
            meas(30, 1'b0, 1'b1);
            check(5, (m == 1) ? 8'h00 : wid[0]);
            dly_in <= 1'b0;
            meas(30, 1'b0, 1'b1);
            check(5, (m == 0) ? 8'h00 : wid[0]);
        end
        wr(OFS_EDGE_FILTER, 8'(3 << EF_DLY_LSB));
        dly_in <= 1'b1;
        tick(2);
        check(6, 8'h00);
        tick(30);
        check(6, 8'h01);
        $display("test delay done");
        tick(2);
        tally_and_finish();
    end
endmodule
